//--- rtl/uss_pkg.sv
// shared constants, modes and carriers of the serial shift unit
// assumes one system clock and one link sampling clock
`default_nettype none
package uss_pkg;

	localparam int DATA_W   = 8;
	localparam int CNT_W    = 4;
	localparam int BUF_W    = 8;
	localparam int BUF_D    = 2;
	localparam int SYNC_LEN = 2;

	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0]  CNT_TOP  = 4'hF;
	localparam int                MSB_POS  = DATA_W - 1;

	typedef enum logic [1:0] {
		USS_WIRE_OFF   = 2'h0,
		USS_WIRE_THREE = 2'h1,
		USS_WIRE_TWO   = 2'h2
	} uss_wire_e;

	typedef enum logic [1:0] {
		USS_SRC_NONE  = 2'h0,
		USS_SRC_SW    = 2'h1,
		USS_SRC_TIMER = 2'h2,
		USS_SRC_PIN   = 2'h3
	} uss_src_e;

	typedef enum logic [2:0] {
		USS_HOLD_IDLE  = 3'h1,
		USS_HOLD_START = 3'h2,
		USS_HOLD_OVF   = 3'h4
	} uss_hold_e;

	typedef struct packed {
		uss_wire_e wire_mode;
		uss_src_e  clk_src;
		logic      edge_select_bit;
		logic      master_en;
		logic      hold_on_ovf;
	} uss_cfg_s;

	typedef struct packed {
		logic data_o;
		logic data_oe;
		logic clk_o;
		logic clk_oe;
	} uss_pins_s;

endpackage : uss_pkg
`default_nettype wire

//--- rtl/uss_buf2.sv
// two-entry valid/ready buffer for completed bytes
// assumes both sides on the same clock
`timescale 1ns/1ps
`default_nettype none
module uss_buf2
	import uss_pkg::*;
#(
	parameter int W = BUF_W,
	parameter int D = BUF_D
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem [D];
	logic         wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0]   cnt_reg, cnt_next;
	logic         push, pop;

	assign in_ready  = (cnt_reg != 2'(D));
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = mem[rp_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		wp_next  = push ? ~wp_reg : wp_reg;
		rp_next  = pop ? ~rp_reg : rp_reg;
		cnt_next = cnt_reg + 2'(push) - 2'(pop);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage needs no reset; valid gates every read
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end
endmodule : uss_buf2
`default_nettype wire

//--- rtl/uss_core.sv
// serial shift unit: shift register, edge counter, two-wire clock control
// assumes pins sampled by link_clk; processor strobes on ref_clk
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - eight-bit shift register, directly readable and writable by software
// - completed bytes go to a two-entry buffer and are dropped while it is full; the shift register keeps a byte only until further shifting
// - shift msb goes to data pin chosen by wire mode
// - output latch changes data pin on edge opposite to sampling with pin clock; follows msb with internal clocks
// - serial input always taken from the data-in pin
// - four-bit counter readable, writable, overflow marks transfer done
// - shift register and counter advance on one selected clock
// - external pin clock: counter counts both edges
// - clock source: pin, timer compare match, or software strobe
// - two-wire start condition detected and flagged
// - two-wire wait states hold clock low after start or overflow
// - two-wire events wake from any sleep; otherwise idle only
// - two-wire and three-wire, master or slave
// - edge select low: sample rising, shift falling; high: opposite
// - external clock overflows after sixteen edges, eight pulses
// - three-wire modes 0 and 1, no hardware slave select
module uss_core
	import uss_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              link_clk,
	input  wire logic              link_arst_n,
	input  wire uss_cfg_s          cfg,
	input  wire logic              serial_clock_pin,
	input  wire logic              serial_data_in,
	input  wire logic              compare_match_timer,
	input  wire logic              clock_toggle_strobe,
	input  wire logic              sw_shift_strobe,
	input  wire logic              data_wr,
	input  wire logic [DATA_W-1:0] data_wdata,
	input  wire logic              cnt_wr,
	input  wire logic [CNT_W-1:0]  cnt_wdata,
	input  wire logic              ovf_clr,
	input  wire logic              start_clr,
	output logic      [DATA_W-1:0] shift_data_register,
	output logic      [CNT_W-1:0]  edge_count,
	output logic                   count_overflow_flag,
	output logic                   start_flag,
	output logic                   wake_any_sleep,
	output logic                   wake_idle,
	output uss_pins_s              pins,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic      [BUF_W-1:0]  rx_data,
	output logic                   rx_stall
);
	// ------------------------------------------------------------
	// link side: pin synchronisers and edge capture
	// ------------------------------------------------------------
	logic [SYNC_LEN-1:0] lk_sck_sy, lk_di_sy;
	logic lk_sck_prev, lk_di_prev;
	logic lk_edge_tgl_reg, lk_edge_tgl_next;
	logic lk_lvl_reg, lk_lvl_next;
	logic lk_bit_reg, lk_bit_next;
	logic lk_start_tgl_reg, lk_start_tgl_next;
	logic lk_sck, lk_di;

	assign lk_sck = lk_sck_sy[SYNC_LEN-1];
	assign lk_di  = lk_di_sy[SYNC_LEN-1];

	// level and bit are held until the next toggle, so the ref side
	// may read them safely once the toggle has crossed
	always_comb begin
		lk_edge_tgl_next  = lk_edge_tgl_reg;
		lk_lvl_next       = lk_lvl_reg;
		lk_bit_next       = lk_bit_reg;
		lk_start_tgl_next = lk_start_tgl_reg;
		if (lk_sck != lk_sck_prev) begin
			lk_edge_tgl_next = ~lk_edge_tgl_reg;
			lk_lvl_next      = lk_sck;
			lk_bit_next      = lk_di;
		end
		if (lk_sck && lk_sck_prev && lk_di_prev && !lk_di) begin
			lk_start_tgl_next = ~lk_start_tgl_reg;
		end
	end

	always_ff @(posedge link_clk or negedge link_arst_n) begin
		if (!link_arst_n) begin
			lk_sck_sy        <= '0;
			lk_di_sy         <= '1;
			lk_sck_prev      <= 1'b0;
			lk_di_prev       <= 1'b1;
			lk_edge_tgl_reg  <= 1'b0;
			lk_lvl_reg       <= 1'b0;
			lk_bit_reg       <= 1'b0;
			lk_start_tgl_reg <= 1'b0;
		end else begin
			lk_sck_sy        <= {lk_sck_sy[0], serial_clock_pin};
			lk_di_sy         <= {lk_di_sy[0], serial_data_in};
			lk_sck_prev      <= lk_sck;
			lk_di_prev       <= lk_di;
			lk_edge_tgl_reg  <= lk_edge_tgl_next;
			lk_lvl_reg       <= lk_lvl_next;
			lk_bit_reg       <= lk_bit_next;
			lk_start_tgl_reg <= lk_start_tgl_next;
		end
	end

	// ------------------------------------------------------------
	// crossing into ref_clk
	// ------------------------------------------------------------
	logic [SYNC_LEN:0] edge_sy, start_sy;
	logic [SYNC_LEN-1:0] di_sy;
	logic edge_evt, start_evt, ref_di;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_sy  <= '0;
			start_sy <= '0;
			di_sy    <= '1;
		end else begin
			edge_sy  <= {edge_sy[SYNC_LEN-1:0], lk_edge_tgl_reg};
			start_sy <= {start_sy[SYNC_LEN-1:0], lk_start_tgl_reg};
			di_sy    <= {di_sy[0], serial_data_in};
		end
	end

	assign edge_evt  = edge_sy[SYNC_LEN] ^ edge_sy[SYNC_LEN-1];
	assign start_evt = start_sy[SYNC_LEN] ^ start_sy[SYNC_LEN-1];
	assign ref_di    = di_sy[SYNC_LEN-1];

	// ------------------------------------------------------------
	// clock selection
	// ------------------------------------------------------------
	logic two_wire, pin_src, tick_int, samp_edge, out_edge, adv;

	assign two_wire = (cfg.wire_mode == USS_WIRE_TWO);
	assign pin_src  = (cfg.clk_src == USS_SRC_PIN);
	assign tick_int = ((cfg.clk_src == USS_SRC_SW) & sw_shift_strobe)
		| ((cfg.clk_src == USS_SRC_TIMER) & compare_match_timer);
	// lk_lvl_reg is the pin level after the edge: high means rising
	assign samp_edge = pin_src & edge_evt
		& (lk_lvl_reg ^ cfg.edge_select_bit);
	assign out_edge  = pin_src & edge_evt
		& ~(lk_lvl_reg ^ cfg.edge_select_bit);
	assign adv = tick_int | (pin_src & edge_evt);

	// ------------------------------------------------------------
	// shift register, counter, latch, flags
	// ------------------------------------------------------------
	logic [DATA_W-1:0] shift_reg, shift_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	logic latch_reg, latch_next;
	logic ovf_reg, ovf_next, start_reg, start_next;
	logic sck_out_reg, sck_out_next;
	logic wrap, buf_ready;

	assign wrap = adv & ~cnt_wr & (cnt_reg == CNT_TOP);

	always_comb begin
		shift_next   = shift_reg;
		cnt_next     = cnt_reg;
		latch_next   = latch_reg;
		sck_out_next = sck_out_reg ^ clock_toggle_strobe;
		if (samp_edge || tick_int) begin
			shift_next = {shift_reg[DATA_W-2:0],
				pin_src ? lk_bit_reg : ref_di};
		end
		if (data_wr) begin
			shift_next = data_wdata;
		end
		// internal clocks have no opposite edge, and a write goes
		// straight through: the latch is open while an internal clock is selected
		if (out_edge || data_wr || !pin_src) begin
			latch_next = shift_next[MSB_POS];
		end
		if (cnt_wr) begin
			cnt_next = cnt_wdata;
		end else if (adv) begin
			cnt_next = cnt_reg + CNT_ONE;
		end
		// set wins over a clear in the same cycle
		ovf_next   = wrap | (ovf_reg & ~ovf_clr);
		start_next = (two_wire & start_evt)
			| (start_reg & ~start_clr);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg   <= DATA_RST;
			cnt_reg     <= CNT_RST;
			latch_reg   <= 1'b0;
			ovf_reg     <= 1'b0;
			start_reg   <= 1'b0;
			sck_out_reg <= 1'b0;
		end else begin
			shift_reg   <= shift_next;
			cnt_reg     <= cnt_next;
			latch_reg   <= latch_next;
			ovf_reg     <= ovf_next;
			start_reg   <= start_next;
			sck_out_reg <= sck_out_next;
		end
	end

	// ------------------------------------------------------------
	// two-wire clock hold
	// ------------------------------------------------------------
	uss_hold_e hold_reg, hold_next;

	always_comb begin
		hold_next = hold_reg;
		case (hold_reg)
			USS_HOLD_IDLE: begin
				if (two_wire && start_evt) begin
					hold_next = USS_HOLD_START;
				end else if (two_wire && cfg.hold_on_ovf && wrap) begin
					hold_next = USS_HOLD_OVF;
				end
			end
			USS_HOLD_START: begin
				if (start_clr || !two_wire) begin
					hold_next = USS_HOLD_IDLE;
				end
			end
			USS_HOLD_OVF: begin
				if (ovf_clr || !two_wire) begin
					hold_next = USS_HOLD_IDLE;
				end
			end
			default: hold_next = USS_HOLD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= USS_HOLD_IDLE;
		end else begin
			hold_reg <= hold_next;
		end
	end

	// ------------------------------------------------------------
	// received byte buffer
	// ------------------------------------------------------------
	uss_buf2 u_buf (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_valid  (wrap),
		.in_ready  (buf_ready),
		.in_data   (shift_next),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// full buffer stretches the two-wire clock so the remote end waits;
	// three-wire has no such back-pressure, software must watch rx_stall
	assign rx_stall = ~buf_ready;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic holding;

	assign holding = (hold_reg != USS_HOLD_IDLE) | (two_wire & ~buf_ready);

	always_comb begin
		pins = '0;
		case (cfg.wire_mode)
			USS_WIRE_THREE: begin
				pins.data_o  = latch_reg;
				pins.data_oe = 1'b1;
				pins.clk_o   = sck_out_reg;
				pins.clk_oe  = cfg.master_en;
			end
			USS_WIRE_TWO: begin
				pins.data_o  = 1'b0;
				pins.data_oe = ~latch_reg;
				pins.clk_o   = 1'b0;
				pins.clk_oe  = holding | (cfg.master_en & ~sck_out_reg);
			end
			default: pins = '0;
		endcase
	end

	assign shift_data_register = shift_reg;
	assign edge_count          = cnt_reg;
	assign count_overflow_flag = ovf_reg;
	assign start_flag          = start_reg;
	assign wake_idle           = ovf_reg | start_reg;
	assign wake_any_sleep      = two_wire & (ovf_reg | start_reg);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	ovf_on_wrap_a: assert property (
		adv && !cnt_wr && cnt_reg == CNT_TOP |=> ovf_reg && cnt_reg == '0)
		else $error("overflow flag missed on counter wrap");
	ovf_sticky_a: assert property (
		ovf_reg && !ovf_clr |=> ovf_reg)
		else $error("overflow flag dropped without clear");
	cnt_step_a: assert property (
		adv && !cnt_wr |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
		else $error("counter did not advance with shift clock");
	cnt_idle_a: assert property (
		!adv && !cnt_wr |=> $stable(cnt_reg))
		else $error("counter moved without clock");
	shift_in_a: assert property (
		samp_edge && !data_wr |=>
		shift_reg == {$past(shift_reg[DATA_W-2:0]), $past(lk_bit_reg)})
		else $error("sampled bit not shifted in");
	latch_hold_a: assert property (
		pin_src && !out_edge && !data_wr && $stable(cfg) |=>
		$stable(latch_reg))
		else $error("output latch changed off its edge");
	start_set_a: assert property (
		two_wire && start_evt |=> start_reg)
		else $error("start condition not flagged");
	hold_start_a: assert property (
		two_wire && start_evt && hold_reg == USS_HOLD_IDLE |=>
		hold_reg == USS_HOLD_START ##0 pins.clk_oe)
		else $error("clock not held after start");
	wake_mode_a: assert property (
		!two_wire |-> !wake_any_sleep)
		else $error("deep wake outside two-wire mode");
	msb_pin_a: assert property (
		cfg.wire_mode == USS_WIRE_THREE && out_edge && !data_wr |=>
		pins.data_o == $past(shift_reg[MSB_POS]))
		else $error("data pin not fed from shift msb");
endmodule : uss_core
`default_nettype wire

//--- tb/uss_remote.sv
// remote three-wire master driving the shift unit's clock and data pins
// assumes the bench routes its outputs onto the pins throughout its pin transfer tests, between frames too
`timescale 1ns/1ps
`default_nettype none
module uss_remote (
	input  wire logic link_clk,
	input  wire logic miso,
	output logic       sck,
	output logic       mosi,
	output logic [7:0] rx_byte
);
	initial begin
		sck = 1'h0;
		mosi = 1'h0;
		rx_byte = 8'h00;
	end

	// half: link cycles per half period, larger values model a slow peer
	task automatic xfer(input logic [7:0] tx, input logic cpha,
		input int half);
		// move only off a link edge, so no pin changes as it is sampled
		@(posedge link_clk);
		#2;
		for (int i = 7; i >= 0; i--) begin
			if (cpha)
				sck = 1'h1;
			mosi = tx[i];
			repeat (half) @(posedge link_clk);
			#2;
			sck = cpha ? 1'h0 : 1'h1;
			rx_byte = {rx_byte[6:0], miso};
			repeat (half) @(posedge link_clk);
			#2;
			if (!cpha)
				sck = 1'h0;
		end
		// a released line must not keep showing the last bit
		mosi = ~mosi;
	endtask : xfer
endmodule : uss_remote
`default_nettype wire

//--- tb/universal_serial_shift_unit_test.sv
// self-checking bench of the serial shift unit core
// assumes uss_pkg, uss_core and the remote model uss_remote
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shift_unit_test
	import uss_pkg::*;
;
	logic              ref_clk;
	logic              link_clk;
	logic              arst_n;
	uss_cfg_s          cfg;
	logic              tb_sck;
	logic              tb_din;
	logic              use_rem;
	logic              compare_match_timer;
	logic              clock_toggle_strobe;
	logic              sw_shift_strobe;
	logic              data_wr;
	logic              cnt_wr;
	logic              ovf_clr;
	logic              start_clr;
	logic              rx_ready;
	logic [DATA_W-1:0] data_wdata;
	logic [DATA_W-1:0] shift_data_register;
	logic [BUF_W-1:0]  rx_data;
	logic [CNT_W-1:0]  cnt_wdata;
	logic [CNT_W-1:0]  edge_count;
	logic              count_overflow_flag;
	logic              start_flag;
	logic              wake_any_sleep;
	logic              wake_idle;
	logic              rx_valid;
	logic              rx_stall;
	uss_pins_s         pins;
	wire logic         r_sck;
	wire logic         r_mosi;
	wire logic [7:0]   r_rx;
	int                err_count;
	int                comparisons;

	// open-drain pull-down by the unit in two-wire mode
	wire logic two_w = cfg.wire_mode == USS_WIRE_TWO;
	wire logic serial_clock_pin = (use_rem ? r_sck : tb_sck)
		& ~(two_w & pins.clk_oe);
	wire logic serial_data_in = (use_rem ? r_mosi : tb_din)
		& ~(two_w & pins.data_oe);

	typedef struct {
		uss_src_e   src;
		logic       din;
		logic [7:0] pre;
		int         n;
		logic [7:0] exp_d;
		logic [3:0] exp_c;
		logic       exp_o;
	} uss_row_s;

	uss_row_s rows [5] = '{
		'{USS_SRC_SW,    1'h1, 8'hA5, 3,  8'h2F, 4'h3, 1'h0},
		'{USS_SRC_TIMER, 1'h0, 8'h3C, 4,  8'hC0, 4'h4, 1'h0},
		'{USS_SRC_NONE,  1'h1, 8'h5A, 5,  8'h5A, 4'h0, 1'h0},
		'{USS_SRC_SW,    1'h0, 8'h81, 16, 8'h00, 4'h0, 1'h1},
		'{USS_SRC_TIMER, 1'h1, 8'h00, 16, 8'hFF, 4'h0, 1'h1}
	};

	always #5 ref_clk = ~ref_clk;
	always #6 link_clk = ~link_clk;

	uss_core u_dut (
		.ref_clk, .arst_n, .link_clk, .link_arst_n(arst_n), .cfg,
		.serial_clock_pin, .serial_data_in, .compare_match_timer,
		.clock_toggle_strobe, .sw_shift_strobe, .data_wr, .data_wdata,
		.cnt_wr, .cnt_wdata, .ovf_clr, .start_clr, .shift_data_register,
		.edge_count, .count_overflow_flag, .start_flag, .wake_any_sleep,
		.wake_idle, .pins, .rx_valid, .rx_ready, .rx_data, .rx_stall
	);

	uss_remote u_rem (
		.link_clk, .miso(pins.data_o), .sck(r_sck), .mosi(r_mosi),
		.rx_byte(r_rx)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk_byte(input string nm, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte

	task automatic chk_bit(input string nm, input logic e, g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask : chk_bit

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : cyc

	// one-cycle strobes; tk pulses both internal shift sources at once
	task automatic step(input logic dw, input logic [7:0] d,
		input logic cw, input logic [3:0] c, input logic clr,
		input logic tk);
		data_wr = dw;
		data_wdata = d;
		cnt_wr = cw;
		cnt_wdata = c;
		ovf_clr = clr;
		start_clr = clr;
		sw_shift_strobe = tk;
		compare_match_timer = tk;
		cyc(1);
		{data_wr, cnt_wr, ovf_clr, start_clr} = 4'h0;
		{sw_shift_strobe, compare_match_timer} = 2'h0;
		cyc(1);
	endtask : step

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'h0;
		link_clk = 1'h1;
		arst_n = 1'h0;
		cfg = '{USS_WIRE_THREE, USS_SRC_NONE, 1'h0, 1'h1, 1'h0};
		{tb_sck, tb_din, use_rem, rx_ready} = 4'h0;
		{compare_match_timer, clock_toggle_strobe} = 2'h0;
		{sw_shift_strobe, data_wr, cnt_wr, ovf_clr, start_clr} = 5'h00;
		data_wdata = 8'h00;
		cnt_wdata = 4'h0;
		err_count = 0;
		comparisons = 0;
		cyc(3);
		arst_n = 1'h1;
		chk_byte("reset data", DATA_RST, shift_data_register);
		chk_byte("reset count", 8'h00, {4'h0, edge_count});
		chk_bit("reset valid", 1'h0, rx_valid);
		$display("reset test done");
		foreach (rows[i]) begin
			cfg.clk_src = rows[i].src;
			tb_din = rows[i].din;
			step(1'h1, rows[i].pre, 1'h1, 4'h0, 1'h1, 1'h0);
			cyc(8);
			repeat (rows[i].n) step(1'h0, 8'h00, 1'h0, 4'h0, 1'h0, 1'h1);
			cyc(2);
			chk_byte("data", rows[i].exp_d, shift_data_register);
			chk_byte("count", {4'h0, rows[i].exp_c}, {4'h0, edge_count});
			chk_bit("overflow", rows[i].exp_o, count_overflow_flag);
			$display("row %0d done", i);
		end
		// receiver stalled through both overflows: buffer must be full
		chk_bit("buffer full", 1'h1, rx_stall);
		chk_byte("first byte", 8'h00, rx_data);
		rx_ready = 1'h1;
		cyc(1);
		chk_byte("second byte", 8'hFF, rx_data);
		cyc(1);
		chk_bit("buffer empty", 1'h0, rx_valid);
		$display("buffer test done");
		step(1'h0, 8'h00, 1'h1, CNT_TOP, 1'h1, 1'h0);
		step(1'h0, 8'h00, 1'h0, 4'h0, 1'h1, 1'h1);
		chk_bit("set over clear", 1'h1, count_overflow_flag);
		chk_byte("wrapped count", 8'h00, {4'h0, edge_count});
		chk_bit("idle wake", 1'h1, wake_idle);
		chk_bit("deep wake off", 1'h0, wake_any_sleep);
		step(1'h0, 8'h00, 1'h0, 4'h0, 1'h1, 1'h0);
		chk_bit("flag cleared", 1'h0, count_overflow_flag);
		// timer selected: a software strobe alone must not shift
		sw_shift_strobe = 1'h1;
		cyc(1);
		sw_shift_strobe = 1'h0;
		cyc(1);
		chk_byte("wrong source", 8'h00, {4'h0, edge_count});
		step(1'h1, 8'h99, 1'h0, 4'h0, 1'h0, 1'h1);
		chk_byte("write over shift", 8'h99, shift_data_register);
		for (int i = 0; i < 2; i++) begin
			clock_toggle_strobe = 1'h1;
			cyc(1);
			clock_toggle_strobe = 1'h0;
			cyc(1);
			chk_bit("toggled clock", (i == 0), pins.clk_o);
		end
		$display("hand tests done");
		cfg.clk_src = USS_SRC_PIN;
		cfg.master_en = 1'h0;
		use_rem = 1'h1;
		for (int i = 0; i < 2; i++) begin
			logic [7:0] pre;
			logic [7:0] tx;
			pre = i ? 8'h96 : 8'hC3;
			tx = i ? 8'h3D : 8'h5A;
			cfg.edge_select_bit = i[0];
			step(1'h1, pre, 1'h1, 4'h0, 1'h1, 1'h0);
			u_rem.xfer(tx, i[0], 8 + 4 * i);
			cyc(10);
			chk_byte("pin rx", tx, shift_data_register);
			chk_byte("pin tx", pre, r_rx);
			chk_byte("pin count", 8'h00, {4'h0, edge_count});
			chk_bit("pin overflow", 1'h1, count_overflow_flag);
			chk_bit("slave clock off", 1'h0, pins.clk_oe);
			$display("pin transfer %0d done", i);
		end
		use_rem = 1'h0;
		cfg = '{USS_WIRE_TWO, USS_SRC_PIN, 1'h0, 1'h0, 1'h0};
		// a set msb lets the data line go before a start is made
		step(1'h1, 8'hFF, 1'h0, 4'h0, 1'h1, 1'h0);
		tb_din = 1'h1;
		cyc(8);
		tb_sck = 1'h1;
		cyc(8);
		tb_din = 1'h0;
		cyc(8);
		chk_bit("start seen", 1'h1, start_flag);
		chk_bit("clock held", 1'h1, pins.clk_oe);
		chk_bit("held low", 1'h0, pins.clk_o);
		chk_bit("deep wake", 1'h1, wake_any_sleep);
		step(1'h0, 8'h00, 1'h0, 4'h0, 1'h1, 1'h0);
		chk_bit("start cleared", 1'h0, start_flag);
		chk_bit("clock released", 1'h0, pins.clk_oe);
		chk_bit("line released", 1'h1, serial_clock_pin);
		$display("start test done");
		cyc(8);
		cfg.hold_on_ovf = 1'h1;
		step(1'h0, 8'h00, 1'h1, CNT_TOP, 1'h0, 1'h0);
		tb_sck = 1'h0;
		cyc(10);
		chk_bit("overflow hold", 1'h1, pins.clk_oe);
		chk_bit("hold overflow flag", 1'h1, count_overflow_flag);
		step(1'h0, 8'h00, 1'h0, 4'h0, 1'h1, 1'h0);
		chk_bit("overflow release", 1'h0, pins.clk_oe);
		$display("overflow hold test done");
		report_and_stop();
	end
endmodule : universal_serial_shift_unit_test
`default_nettype wire
